/* src/cbb_defs.vh */
// Purpose: Shared constants for the bit, branch and cycle timing block.
// Assumes: Included by every design file of the block by bare name.
// Notes:   Definitions only; opcodes follow the classic instruction map.
`ifndef CBB_DEFS_VH
`define CBB_DEFS_VH

// -----------------------------------------------------------------------
// Machine cycle states and reset values
// -----------------------------------------------------------------------
`define CBB_S1 2'h0
`define CBB_S2 2'h1
`define CBB_S3 2'h2
`define CBB_PC_RST 16'h0000
`define CBB_CLK_NS 100
`define CBB_MC_STATES 3

// -----------------------------------------------------------------------
// Bit address map and operand modes
// -----------------------------------------------------------------------
`define CBB_BIT_SFR_MSB 7
`define CBB_BIT_RAM_BASE 8'h20
`define CBB_CY_BIT 8'hD7
`define CBB_OPM_DIR 2'h0
`define CBB_OPM_REG 2'h1
`define CBB_OPM_IND 2'h2

// -----------------------------------------------------------------------
// Opcodes handled here
// -----------------------------------------------------------------------
`define CBB_OP_NOP 8'h00
`define CBB_OP_PAGE_ABSOLUTE_JUMP 5'h01
`define CBB_OP_PAGE_CALL 5'h11
`define CBB_OP_LONG_ABSOLUTE_JUMP 8'h02
`define CBB_OP_LONG_CALL 8'h12
`define CBB_OP_RET 8'h22
`define CBB_OP_INTERRUPT_RETURN 8'h32
`define CBB_OP_SHORT_RELATIVE_JUMP 8'h80
`define CBB_OP_JMPI 8'h73
`define CBB_OP_JC 8'h40
`define CBB_OP_JNC 8'h50
`define CBB_OP_JB 8'h20
`define CBB_OP_JNB 8'h30
`define CBB_OP_JBC 8'h10
`define CBB_OP_JZ 8'h60
`define CBB_OP_JNZ 8'h70
`define CBB_OP_DECREMENT_JUMP_NONZERO_D 8'hD5
`define CBB_OP_DECREMENT_JUMP_NONZERO_R 5'h1B
`define CBB_OP_COMPARE_JUMP_UNEQUAL_AI 8'hB4
`define CBB_OP_COMPARE_JUMP_UNEQUAL_AD 8'hB5
`define CBB_OP_COMPARE_JUMP_UNEQUAL_A 7'h5A
`define CBB_OP_COMPARE_JUMP_UNEQUAL_I 6'h2D
`define CBB_OP_COMPARE_JUMP_UNEQUAL_R 5'h17
`define CBB_OP_ANL_C 8'h82
`define CBB_OP_ANL_CN 8'hB0
`define CBB_OP_ORL_C 8'h72
`define CBB_OP_ORL_CN 8'hA0
`define CBB_OP_MOV_CB 8'hA2
`define CBB_OP_MOV_BC 8'h92
`define CBB_OP_CLR_C 8'hC3
`define CBB_OP_CLR_B 8'hC2
`define CBB_OP_SET_C 8'hD3
`define CBB_OP_SET_B 8'hD2
`define CBB_OP_CPL_C 8'hB3
`define CBB_OP_CPL_B 8'hB2
`define CBB_OP_EXTERNAL_DATA_MOVE_RD 8'hE0
`define CBB_OP_EXTERNAL_DATA_MOVE_WR 8'hF0
`define CBB_OP_EXTERNAL_DATA_MOVE_RI 7'h71
`define CBB_OP_EXTERNAL_DATA_MOVE_WI 7'h79

`endif

/* src/cbb_bit_map.v */
// Purpose: Maps a direct bit address onto a byte address and bit index.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Low half lands in the bit area of lower RAM, high half in SFRs.
`timescale 1ns/100ps
`include "cbb_defs.vh"

module cbb_bit_map (
  input wire [7:0] bit_addr_i,
  output reg [7:0] byte_addr_o,
  output reg [2:0] index_o,
  output reg sfr_o
);

  // -----------------------------------------------------------------------
  // Address split
  // -----------------------------------------------------------------------
  // Only SFRs on an eight byte boundary are bit addressable, so the low
  // three address bits select the bit and the rest name the register.
  always @*
  begin
    index_o = bit_addr_i[2:0];
    sfr_o = bit_addr_i[`CBB_BIT_SFR_MSB];
    if (bit_addr_i[`CBB_BIT_SFR_MSB])
      byte_addr_o = {bit_addr_i[7:3], 3'h0};
    else
      byte_addr_o = `CBB_BIT_RAM_BASE + {4'h0, bit_addr_i[6:3]};
  end

endmodule

/* src/cbb_core.v */
// Purpose: Boolean processor, jumps, calls, returns and fetch timing.
// Assumes: Operand, bit and stack values answer within the same state.
// Notes:   Foreign opcodes run one machine cycle, length from other_len_i.
`timescale 1ns/100ps
`include "cbb_defs.vh"

module cbb_core (
  input wire clk_i,
  input wire nrst_i,
  input wire ext_code_i,
  input wire [7:0] code_data_i,
  input wire [1:0] other_len_i,
  input wire bit_val_i,
  input wire [7:0] operand_i,
  input wire [7:0] acc_i,
  input wire [15:0] data_pointer_i,
  input wire [15:0] stack_addr_i,
  input wire int_active_i,
  input wire carry_wr_i,
  input wire carry_val_i,
  output reg [15:0] code_addr_o,
  output reg code_rd_o,
  output reg prog_fetch_strobe_n_o,
  output reg xdata_bus_o,
  output wire [1:0] mc_state_o,
  output wire [15:0] pc_o,
  output wire [7:0] ins_op_o,
  output wire [7:0] next_op_o,
  output reg [7:0] bit_byte_o,
  output reg [2:0] bit_index_o,
  output reg bit_sfr_o,
  output reg bit_wr_o,
  output reg bit_wr_val_o,
  output reg [7:0] opnd_addr_o,
  output reg [1:0] opnd_mode_o,
  output reg byte_wr_o,
  output reg [7:0] byte_wr_val_o,
  output wire carry_o,
  output reg push_o,
  output reg [15:0] push_addr_o,
  output reg pop_o,
  output reg int_done_o
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  reg ext_m_r, ext_s_r;
  reg [1:0] st_r;
  reg boot_r, valid_r, second_r, cy_r, cy_sel_r;
  reg [15:0] pc_r, fbase_r, tgt_r;
  reg [7:0] win0_r, win1_r, win2_r, f0_r, f1_r;
  reg [1:0] wlen_r;
  reg adv, new_valid, bw, bwv, taken, cy_nxt, xbus_nxt;
  reg [15:0] new_pc, fbase_nxt, tgt_nxt;
  reg [7:0] lhs, rhs;
  wire [7:0] map_byte;
  wire [2:0] map_idx;
  wire map_sfr;

  // Length of an opcode; foreign opcodes take the outer decoder's figure.
  function [1:0] cbb_len;
    input [7:0] o;
    input [1:0] other;
    begin
      case (o)
        `CBB_OP_LONG_ABSOLUTE_JUMP, `CBB_OP_LONG_CALL, `CBB_OP_JB, `CBB_OP_JNB,
        `CBB_OP_JBC, `CBB_OP_DECREMENT_JUMP_NONZERO_D:
          cbb_len = 2'd3;
        `CBB_OP_SHORT_RELATIVE_JUMP, `CBB_OP_JC, `CBB_OP_JNC, `CBB_OP_JZ, `CBB_OP_JNZ,
        `CBB_OP_ANL_C, `CBB_OP_ANL_CN, `CBB_OP_ORL_C, `CBB_OP_ORL_CN,
        `CBB_OP_MOV_CB, `CBB_OP_MOV_BC, `CBB_OP_CLR_B, `CBB_OP_SET_B,
        `CBB_OP_CPL_B:
          cbb_len = 2'd2;
        `CBB_OP_NOP, `CBB_OP_RET, `CBB_OP_INTERRUPT_RETURN, `CBB_OP_JMPI,
        `CBB_OP_CLR_C, `CBB_OP_SET_C, `CBB_OP_CPL_C:
          cbb_len = 2'd1;
        default:
          if (o[3:0] == 4'h1 || o[7:3] == `CBB_OP_DECREMENT_JUMP_NONZERO_R)
            cbb_len = 2'd2;
          else if (o[7:3] == `CBB_OP_COMPARE_JUMP_UNEQUAL_R || o[7:2] == `CBB_OP_COMPARE_JUMP_UNEQUAL_I)
            cbb_len = 2'd3;
          else if (o[7:1] == `CBB_OP_EXTERNAL_DATA_MOVE_RI || o[7:1] == `CBB_OP_EXTERNAL_DATA_MOVE_WI
                   || o == `CBB_OP_EXTERNAL_DATA_MOVE_RD || o == `CBB_OP_EXTERNAL_DATA_MOVE_WR)
            cbb_len = 2'd1;
          else
            cbb_len = other;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------------
  // Decode of the executing instruction
  // -----------------------------------------------------------------------
  wire [7:0] op = win0_r;
  wire is_page_absolute_jump = (op[4:0] == `CBB_OP_PAGE_ABSOLUTE_JUMP);
  wire is_page_call = (op[4:0] == `CBB_OP_PAGE_CALL);
  wire is_decrement_jump_nonzero = (op == `CBB_OP_DECREMENT_JUMP_NONZERO_D) || (op[7:3] == `CBB_OP_DECREMENT_JUMP_NONZERO_R);
  wire is_compare_jump_unequal = (op[7:2] == `CBB_OP_COMPARE_JUMP_UNEQUAL_I) || (op[7:3] == `CBB_OP_COMPARE_JUMP_UNEQUAL_R);
  wire is_external_data_move = (op[7:1] == `CBB_OP_EXTERNAL_DATA_MOVE_RI) ||
                 (op[7:1] == `CBB_OP_EXTERNAL_DATA_MOVE_WI) ||
                 (op == `CBB_OP_EXTERNAL_DATA_MOVE_RD) || (op == `CBB_OP_EXTERNAL_DATA_MOVE_WR);
  wire is_call = is_page_call || (op == `CBB_OP_LONG_CALL);
  wire is_ret = (op == `CBB_OP_RET) || (op == `CBB_OP_INTERRUPT_RETURN);
  wire is_jbit = (op == `CBB_OP_JB) || (op == `CBB_OP_JNB) ||
                 (op == `CBB_OP_JBC);
  wire is_bop = (op == `CBB_OP_ANL_C) || (op == `CBB_OP_ANL_CN) ||
                (op == `CBB_OP_ORL_C) || (op == `CBB_OP_ORL_CN) ||
                (op == `CBB_OP_MOV_CB) || (op == `CBB_OP_MOV_BC) ||
                (op == `CBB_OP_CLR_B) || (op == `CBB_OP_SET_B) ||
                (op == `CBB_OP_CPL_B);
  wire two_mc = is_page_absolute_jump || is_call || is_ret || is_decrement_jump_nonzero || is_compare_jump_unequal ||
                is_jbit || is_external_data_move || (op == `CBB_OP_SHORT_RELATIVE_JUMP) ||
                (op == `CBB_OP_LONG_ABSOLUTE_JUMP) || (op == `CBB_OP_JMPI) ||
                (op == `CBB_OP_JC) || (op == `CBB_OP_JNC) ||
                (op == `CBB_OP_JZ) || (op == `CBB_OP_JNZ);
  wire [1:0] flen = cbb_len(f0_r, other_len_i);
  wire [15:0] nxt_pc = pc_r + {14'h0000, wlen_r};
  wire [7:0] rel = (wlen_r == 2'd3) ? win2_r : win1_r;
  wire [15:0] rel_tgt = nxt_pc + {{8{rel[7]}}, rel};
  wire bitv = cy_sel_r ? cy_r : bit_val_i;
  wire [7:0] dec = operand_i - 8'h01;
  wire mc_end = (st_r == `CBB_S3);
  wire [1:0] st_nxt = mc_end ? `CBB_S1 : st_r + 2'h1;
  wire act = valid_r && !second_r && (st_r == `CBB_S2);
  wire opnd_ld = valid_r && !second_r && (st_r == `CBB_S1);

  assign mc_state_o = st_r;
  assign pc_o = pc_r;
  assign ins_op_o = win0_r;
  assign next_op_o = f0_r;
  assign carry_o = cy_r;

  cbb_bit_map u_bit_map (
    .bit_addr_i(win1_r),
    .byte_addr_o(map_byte),
    .index_o(map_idx),
    .sfr_o(map_sfr)
  );

  // -----------------------------------------------------------------------
  // Execution: carry, bit writes, branch decision and target
  // -----------------------------------------------------------------------
  always @*
  begin
    cy_nxt = cy_r;
    bw = 1'b0;
    bwv = 1'b0;
    taken = 1'b0;
    lhs = (op[7:1] == `CBB_OP_COMPARE_JUMP_UNEQUAL_A) ? acc_i : operand_i;
    rhs = (op == `CBB_OP_COMPARE_JUMP_UNEQUAL_AD) ? operand_i : win1_r;
    case (op)
      `CBB_OP_ANL_C: cy_nxt = cy_r & bitv;
      `CBB_OP_ANL_CN: cy_nxt = cy_r & ~bitv;
      `CBB_OP_ORL_C: cy_nxt = cy_r | bitv;
      `CBB_OP_ORL_CN: cy_nxt = cy_r | ~bitv;
      `CBB_OP_MOV_CB: cy_nxt = bitv;
      `CBB_OP_CLR_C: cy_nxt = 1'b0;
      `CBB_OP_SET_C: cy_nxt = 1'b1;
      `CBB_OP_CPL_C: cy_nxt = ~cy_r;
      `CBB_OP_MOV_BC: {bw, bwv} = {1'b1, cy_r};
      `CBB_OP_CLR_B: {bw, bwv} = 2'h2;
      `CBB_OP_SET_B: {bw, bwv} = 2'h3;
      `CBB_OP_CPL_B: {bw, bwv} = {1'b1, ~bitv};
      `CBB_OP_JC: taken = cy_r;
      `CBB_OP_JNC: taken = ~cy_r;
      `CBB_OP_JB: taken = bitv;
      `CBB_OP_JNB: taken = ~bitv;
      `CBB_OP_JBC: {taken, bw, bwv} = {bitv, bitv, 1'b0};
      `CBB_OP_JZ: taken = (acc_i == 8'h00);
      `CBB_OP_JNZ: taken = (acc_i != 8'h00);
      `CBB_OP_SHORT_RELATIVE_JUMP: taken = 1'b1;
      default:
        if (is_decrement_jump_nonzero)
          taken = (dec != 8'h00);
        else if (is_compare_jump_unequal)
        begin
          taken = (lhs != rhs);
          cy_nxt = (lhs < rhs);
        end
    endcase
    tgt_nxt = taken ? rel_tgt : nxt_pc;
    if (op == `CBB_OP_LONG_ABSOLUTE_JUMP || op == `CBB_OP_LONG_CALL)
      tgt_nxt = {win1_r, win2_r};
    else if (is_page_absolute_jump || is_page_call)
      tgt_nxt = {nxt_pc[15:11], op[7:5], win1_r};
    else if (op == `CBB_OP_JMPI)
      tgt_nxt = data_pointer_i + {8'h00, acc_i};
    else if (is_ret)
      tgt_nxt = stack_addr_i;
  end

  // -----------------------------------------------------------------------
  // Machine cycle boundary and fetch plan
  // -----------------------------------------------------------------------
  // The S1 address of the next cycle is planned here because the window
  // of that cycle is still arriving; its length comes from the S1 byte.
  always @*
  begin
    adv = 1'b1;
    new_pc = pc_r;
    new_valid = !boot_r;
    if (valid_r && two_mc && !second_r)
      adv = 1'b0;
    else if (valid_r)
    begin
      new_pc = two_mc ? tgt_r : nxt_pc;
      new_valid = !is_external_data_move;
    end
    if (!adv)
      fbase_nxt = tgt_r;
    else if (new_valid)
      fbase_nxt = new_pc + {14'h0000, flen};
    else
      fbase_nxt = new_pc;
    xbus_nxt = valid_r && is_external_data_move && (!mc_end || !second_r);
  end

  // -----------------------------------------------------------------------
  // Pin synchroniser for the external code select
  // -----------------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      {ext_m_r, ext_s_r} <= 2'h0;
    else
      {ext_m_r, ext_s_r} <= {ext_code_i, ext_m_r};
  end

  // -----------------------------------------------------------------------
  // Sequencer, fetch port and window
  // -----------------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= `CBB_S3;
      boot_r <= 1'b1;
      valid_r <= 1'b0;
      second_r <= 1'b0;
      pc_r <= `CBB_PC_RST;
      fbase_r <= `CBB_PC_RST;
      wlen_r <= 2'd1;
      {win0_r, win1_r, win2_r, f0_r, f1_r} <= 40'h0;
      code_addr_o <= `CBB_PC_RST;
      code_rd_o <= 1'b0;
      prog_fetch_strobe_n_o <= 1'b1;
      xdata_bus_o <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      code_addr_o <= (mc_end ? fbase_nxt : fbase_r) + {14'h0000, st_nxt};
      code_rd_o <= !xbus_nxt;
      xdata_bus_o <= xbus_nxt;
      // code source only gates the pin
      prog_fetch_strobe_n_o <= !(!xbus_nxt && ext_s_r);
      if (code_rd_o && st_r == `CBB_S1)
        f0_r <= code_data_i;
      if (code_rd_o && st_r == `CBB_S2)
        f1_r <= code_data_i;
      if (mc_end)
      begin
        boot_r <= 1'b0;
        fbase_r <= fbase_nxt;
        second_r <= !adv;
        if (adv)
        begin
          pc_r <= new_pc;
          valid_r <= new_valid;
          wlen_r <= flen;
          {win2_r, win1_r, win0_r} <= {code_data_i, f1_r, f0_r};
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Operand requests and effects toward the rest of the core
  // -----------------------------------------------------------------------
  // Addresses are held from S2 onward so the S3 write pulses still see the
  // address that was read, never that of the following instruction.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cy_r <= 1'b0;
      cy_sel_r <= 1'b0;
      tgt_r <= `CBB_PC_RST;
      {bit_byte_o, bit_index_o, bit_sfr_o} <= 12'h000;
      {bit_wr_o, bit_wr_val_o, byte_wr_o, push_o, pop_o} <= 5'h00;
      int_done_o <= 1'b0;
      byte_wr_val_o <= 8'h00;
      opnd_addr_o <= 8'h00;
      opnd_mode_o <= `CBB_OPM_DIR;
      push_addr_o <= `CBB_PC_RST;
    end
    else
    begin
      {bit_wr_o, byte_wr_o, push_o, pop_o, int_done_o} <= 5'h00;
      if (opnd_ld)
      begin
        {bit_byte_o, bit_index_o, bit_sfr_o} <= {map_byte, map_idx, map_sfr};
        cy_sel_r <= (is_bop || is_jbit) && (win1_r == `CBB_CY_BIT);
        opnd_addr_o <= win1_r;
        opnd_mode_o <= `CBB_OPM_DIR;
        if (op[7:3] == `CBB_OP_DECREMENT_JUMP_NONZERO_R || op[7:3] == `CBB_OP_COMPARE_JUMP_UNEQUAL_R)
        begin
          opnd_addr_o <= {5'h00, op[2:0]};
          opnd_mode_o <= `CBB_OPM_REG;
        end
        else if (op[7:1] == 7'h5B)
        begin
          opnd_addr_o <= {7'h00, op[0]};
          opnd_mode_o <= `CBB_OPM_IND;
        end
      end
      if (act)
      begin
        tgt_r <= tgt_nxt;
        cy_r <= (bw && cy_sel_r) ? bwv : cy_nxt;
        bit_wr_o <= bw && !cy_sel_r;
        bit_wr_val_o <= bwv;
        byte_wr_o <= is_decrement_jump_nonzero;
        byte_wr_val_o <= dec;
        push_o <= is_call;
        push_addr_o <= nxt_pc;
        pop_o <= is_ret;
        int_done_o <= (op == `CBB_OP_INTERRUPT_RETURN) && int_active_i;
      end
      else if (carry_wr_i)
        cy_r <= carry_val_i;
    end
  end

endmodule

/* test/cbb_core_checker.sv */
// Purpose: Port assertions for the bit, branch and fetch timing core.
// Assumes: One clock domain; nrst_i is asynchronous and active low.
// Notes:   Pulses are judged by the state they appear in, and int_done_o also by opcode.
`timescale 1ns/100ps
`include "cbb_defs.vh"

module cbb_core_checker (
  input wire clk_i,
  input wire nrst_i,
  input wire ext_code_i,
  input wire int_active_i,
  input wire [15:0] code_addr_o,
  input wire code_rd_o,
  input wire prog_fetch_strobe_n_o,
  input wire xdata_bus_o,
  input wire [1:0] mc_state_o,
  input wire [15:0] pc_o,
  input wire [7:0] ins_op_o,
  input wire [7:0] bit_byte_o,
  input wire [2:0] bit_index_o,
  input wire bit_sfr_o,
  input wire bit_wr_o,
  input wire byte_wr_o,
  input wire push_o,
  input wire [15:0] push_addr_o,
  input wire pop_o,
  input wire int_done_o
);
  // -------------------------------------------------------------
  // Clocking and helpers
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Any side-effect pulse; all of them share the same slot.
  wire any_pulse = bit_wr_o | byte_wr_o | push_o | pop_o | int_done_o;

  sequence s_mc;
    mc_state_o == `CBB_S2 ##1 mc_state_o == `CBB_S3
      ##1 mc_state_o == `CBB_S1;
  endsequence
  sequence s_xd;
    xdata_bus_o [*5] ##1 !xdata_bus_o;
  endsequence
  sequence s_ext;
    ext_code_i [*5];
  endsequence

  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  property p_mc_seq;
    mc_state_o == `CBB_S1 |=> s_mc;
  endproperty
  property p_fetch_run;
    mc_state_o == `CBB_S2 && code_rd_o |=> code_rd_o
      && code_addr_o == $past(code_addr_o) + 16'h0001;
  endproperty
  property p_strobe_on;
    s_ext ##0 code_rd_o |-> !prog_fetch_strobe_n_o;
  endproperty
  property p_strobe_src;
    !prog_fetch_strobe_n_o |-> code_rd_o && ext_code_i;
  endproperty
  property p_three_strobes;
    mc_state_o == `CBB_S1 && !prog_fetch_strobe_n_o
      |=> (!prog_fetch_strobe_n_o || xdata_bus_o) [*2];
  endproperty
  property p_xd_len;
    $rose(xdata_bus_o) |-> s_xd;
  endproperty
  property p_xd_start;
    $rose(xdata_bus_o) |-> $past(mc_state_o) == `CBB_S1 && $past(code_rd_o);
  endproperty
  property p_xd_quiet;
    xdata_bus_o |-> !code_rd_o && prog_fetch_strobe_n_o;
  endproperty
  property p_pulse;
    any_pulse |-> mc_state_o == `CBB_S3 ##1 !any_pulse;
  endproperty
  property p_interrupt_return;
    pop_o && ins_op_o == `CBB_OP_INTERRUPT_RETURN |-> int_done_o == int_active_i;
  endproperty
  property p_done_src;
    int_done_o |-> pop_o && ins_op_o == `CBB_OP_INTERRUPT_RETURN;
  endproperty
  property p_push;
    push_o |-> push_addr_o == pc_o + 16'h0003
      || push_addr_o == pc_o + 16'h0002;
  endproperty
  property p_no_cy;
    bit_wr_o |-> !(bit_sfr_o && bit_byte_o == 8'hD0 && bit_index_o == 3'h7);
  endproperty
  property p_bit_map;
    bit_wr_o |-> (bit_sfr_o ? bit_byte_o[7] && bit_byte_o[2:0] == 3'h0
      : bit_byte_o[7:4] == 4'h2);
  endproperty

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  a_mc_seq: assert property (p_mc_seq)
    else $error("bad state order");
  a_fetch_run: assert property (p_fetch_run)
    else $error("fetch address not consecutive");
  a_strobe_on: assert property (p_strobe_on)
    else $error("strobe missing on external fetch");
  a_strobe_src: assert property (p_strobe_src)
    else $error("strobe without external fetch");
  a_three_strobes: assert property (p_three_strobes)
    else $error("fewer than three strobes");
  a_xd_len: assert property (p_xd_len)
    else $error("data access not five states");
  a_xd_start: assert property (p_xd_start)
    else $error("data access not after S1 fetch");
  a_xd_quiet: assert property (p_xd_quiet)
    else $error("fetch during data access");
  a_pulse: assert property (p_pulse)
    else $error("pulse outside S3 or too long");
  a_interrupt_return: assert property (p_interrupt_return)
    else $error("interrupt end wrong");
  a_done_src: assert property (p_done_src)
    else $error("interrupt end without return");
  a_push: assert property (p_push)
    else $error("bad return address");
  a_no_cy: assert property (p_no_cy)
    else $error("carry written as memory bit");
  a_bit_map: assert property (p_bit_map)
    else $error("bit address mapped wrongly");
endmodule

bind cbb_core cbb_core_checker u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .ext_code_i(ext_code_i),
  .int_active_i(int_active_i), .code_addr_o(code_addr_o),
  .code_rd_o(code_rd_o), .prog_fetch_strobe_n_o(prog_fetch_strobe_n_o),
  .xdata_bus_o(xdata_bus_o), .mc_state_o(mc_state_o), .pc_o(pc_o),
  .ins_op_o(ins_op_o), .bit_byte_o(bit_byte_o), .bit_index_o(bit_index_o),
  .bit_sfr_o(bit_sfr_o), .bit_wr_o(bit_wr_o), .byte_wr_o(byte_wr_o),
  .push_o(push_o), .push_addr_o(push_addr_o), .pop_o(pop_o),
  .int_done_o(int_done_o)
);

/* test/cbb_code_mem.sv */
// Purpose: Program memory model feeding code bytes to the core.
// Assumes: Read data answers within the fetch state.
// Notes:   A released bus shows the inverse of the last byte served.
`timescale 1ns/100ps

module cbb_code_mem (
  input wire clk_i,
  input wire [15:0] code_addr_i,
  input wire code_rd_i,
  output wire [7:0] code_data_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;

  // Unwritten space reads as a one-cycle filler opcode.
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
    last_r = 8'h00;
  end

  // Remember the last byte so a released bus can differ from it.
  always @(posedge clk_i)
  begin
    if (code_rd_i)
      last_r <= code_data_o;
  end

  // Stale data would hide a missed fetch, so it is inverted.
  assign code_data_o = code_rd_i ? mem[code_addr_i] : ~last_r;
endmodule

/* test/tb_top.sv */
// Purpose: Self-checking bench for jumps, calls, bit ops and timing.
// Assumes: Program is loaded once and run with external and internal code.
// Notes:   Timing is measured as clocks between program counter changes.
`timescale 1ns/100ps

module tb_top;
  logic clk_i, nrst_i, ext_code_i, bit_val_i, int_active_i;
  logic [7:0] operand_i, acc_i;
  logic [15:0] data_pointer_i, stack_addr_i;
  wire [7:0] code_data_i, ins_op_o, bit_byte_o, byte_wr_val_o;
  wire [15:0] code_addr_o, pc_o, push_addr_o;
  wire [2:0] bit_index_o;
  wire [1:0] mc_state_o;
  wire code_rd_o, prog_fetch_strobe_n_o, xdata_bus_o, bit_sfr_o, bit_wr_o;
  wire bit_wr_val_o, byte_wr_o, carry_o, push_o, pop_o, int_done_o;
  int errors, n_tests, n_done, n_xd;
  logic [15:0] push_a;
  logic [11:0] bit_rec;
  logic [7:0] byte_v;

  cbb_core u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ext_code_i(ext_code_i),
    .code_data_i(code_data_i), .other_len_i(2'h1), .bit_val_i(bit_val_i),
    .operand_i(operand_i), .acc_i(acc_i), .data_pointer_i(data_pointer_i),
    .stack_addr_i(stack_addr_i), .int_active_i(int_active_i),
    .carry_wr_i(1'b0), .carry_val_i(1'b0), .code_addr_o(code_addr_o),
    .code_rd_o(code_rd_o), .prog_fetch_strobe_n_o(prog_fetch_strobe_n_o),
    .xdata_bus_o(xdata_bus_o), .mc_state_o(mc_state_o), .pc_o(pc_o),
    .ins_op_o(ins_op_o), .next_op_o(), .bit_byte_o(bit_byte_o),
    .bit_index_o(bit_index_o), .bit_sfr_o(bit_sfr_o), .bit_wr_o(bit_wr_o),
    .bit_wr_val_o(bit_wr_val_o), .opnd_addr_o(), .opnd_mode_o(),
    .byte_wr_o(byte_wr_o), .byte_wr_val_o(byte_wr_val_o),
    .carry_o(carry_o), .push_o(push_o), .push_addr_o(push_addr_o),
    .pop_o(pop_o), .int_done_o(int_done_o)
  );

  cbb_code_mem u_mem (
    .clk_i(clk_i), .code_addr_i(code_addr_o), .code_rd_i(code_rd_o),
    .code_data_o(code_data_i)
  );

  // -------------------------------------------------------------
  // Clock, pulse recorder and helpers
  // -------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Pulses last one state, so they are latched for later checks.
  always @(posedge clk_i)
  begin
    if (push_o) push_a <= push_addr_o;
    if (byte_wr_o) byte_v <= byte_wr_val_o;
    if (bit_wr_o) bit_rec <= {bit_wr_val_o, bit_index_o, bit_byte_o};
    if (int_done_o) n_done <= n_done + 1;
    if (xdata_bus_o) n_xd <= n_xd + 1;
  end

  task automatic check(input string name, input logic [15:0] seen, exp);
  begin
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask

  // Waits for the next instruction; zero clocks skips the timing check.
  task automatic step(input logic [15:0] exp_pc, input int exp_clk);
    logic [15:0] p;
    int n;
  begin
    p = pc_o;
    n = 0;
    while (pc_o === p && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    check("pc", pc_o, exp_pc);
    if (exp_clk != 0) check("clocks", n[15:0], exp_clk[15:0]);
  end
  endtask

  task automatic put(input logic [15:0] a, input logic [23:0] d, int n);
  begin
    for (int i = 0; i < n; i++)
      u_mem.mem[a + i] = d[23 - 8 * i -: 8];
  end
  endtask

  task automatic do_reset(input logic ext, input logic act);
  begin
    nrst_i = 1'b0;
    ext_code_i = ext;
    int_active_i = act;
    n_done = 0;
    n_xd = 0;
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
  end
  endtask

  task finish_test;
  begin
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_jumps;
  begin
    step(16'h0005, 0); // short jump of plus three
    step(16'h1234, 6); // long jump
    step(16'h1256, 6); // page jump
    step(16'h1258, 6); // zero test not taken
    step(16'h11DA, 6); // backward offset
    step(16'h2005, 6); // indirect jump
    $display("jumps test done");
  end
  endtask

  task automatic t_calls(input logic act);
  begin
    step(16'h3000, 6); // long call
    check("push", push_a, 16'h2008); // return address
    step(16'h2008, 6); // resume after call
    check("int_done", n_done[15:0], {15'h0000, act}); // end signal
    $display("calls test done");
  end
  endtask

  task automatic t_bits;
  begin
    step(16'h2009, 6); // data move in two cycles
    check("xdata", n_xd[15:0], 16'h0005); // five states
    step(16'h200A, 6); // refill cycle, then set carry
    check("carry", {15'h0000, carry_o}, 16'h0001); // set
    step(16'h200F, 6); // test and clear taken
    check("bitwr", {4'h0, bit_rec}, 16'h0524); // bit cleared
    step(16'h2013, 6); // unequal taken
    check("carry", {15'h0000, carry_o}, 16'h0000); // not less
    step(16'h2016, 6); // count ends
    check("dec", {8'h00, byte_v}, 16'h0000); // written back
    step(16'h2017, 3); // no-operation
    $display("bits test done");
  end
  endtask

  // -------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------
  initial
  begin
    nrst_i = 1'b0;
    ext_code_i = 1'b1;
    int_active_i = 1'b1;
    bit_val_i = 1'b1;
    operand_i = 8'h01;
    acc_i = 8'h05;
    data_pointer_i = 16'h2000;
    stack_addr_i = 16'h2008;
    errors = 0;
    n_tests = 0;
    @(negedge clk_i);
    put(16'h0000, 24'h80_0300, 2);
    put(16'h0005, 24'h02_1234, 3);
    put(16'h1234, 24'h41_5600, 2);
    put(16'h1256, 24'h60_1000, 2);
    put(16'h1258, 24'h50_8000, 2);
    put(16'h11DA, 24'h73_0000, 1);
    put(16'h2005, 24'h12_3000, 3);
    put(16'h3000, 24'h32_0000, 1);
    put(16'h2008, 24'hE0_D300, 2);
    put(16'h200A, 24'h10_2502, 3);
    put(16'h200F, 24'hB4_0301, 3);
    put(16'h2013, 24'hD5_3003, 3);
    put(16'h2016, 24'h00_80FE, 3);
    // same timing from external and internal code
    for (int r = 0; r < 2; r++)
    begin
      do_reset(r == 0, r == 0);
      t_jumps;
      t_calls(r == 0);
      t_bits;
    end
    finish_test;
  end

  // Both passes need some 190 clocks; this leaves ample margin.
  initial
  begin
    #(3000 * 100);
    errors++;
    finish_test;
  end
endmodule
